// [ufm_cfg.svh]
// ufm_cfg.svh: addresses, field positions, reset values and counts.
// Assumes it is included ahead of the package and the design modules.
`ifndef UFM_CFG_SVH
`define UFM_CFG_SVH
// Register byte addresses on the AXI4-Lite slave.
`define UFM_A_CTRL 8'h00
`define UFM_A_CFG 8'h04
`define UFM_A_BAUD 8'h08
`define UFM_A_STAT 8'h0C
`define UFM_A_TXD 8'h10
`define UFM_A_RXD 8'h14
`define UFM_A_CMD 8'h18
// Control register bit positions.
`define UFM_C_UNIT 0
`define UFM_C_TXON 1
`define UFM_C_RXON 2
`define UFM_C_WL9 3
`define UFM_C_PAR 4
`define UFM_C_DMATX 5
`define UFM_C_DMARX 6
`define UFM_C_RQFL 7
`define UFM_C_CLFL 8
`define UFM_C_XCVR 9
`define UFM_C_DPOL 10
`define UFM_C_MUTE 11
`define UFM_C_WAKE 12
`define UFM_C_WAKE_HI 13
`define UFM_C_MWID 14
`define UFM_C_LIN 15
`define UFM_C_BLEN 16
`define UFM_C_SCK 17
`define UFM_C_LAST 18
`define UFM_C_PHASE 19
`define UFM_C_IDLV 20
`define UFM_C_TCIRQ 21
`define UFM_C_ERIRQ 22
`define UFM_C_BKIRQ 23
// Status register bit positions.
`define UFM_S_TXEMPTY 0
`define UFM_S_TXDONE 1
`define UFM_S_RXFULL 2
`define UFM_S_IDLE 3
`define UFM_S_FRAME 4
`define UFM_S_OVER 5
`define UFM_S_NOISE 6
`define UFM_S_BREAK 7
`define UFM_S_MSTATE 8
// Configuration register fields.
`define UFM_F_LEAD 4:0
`define UFM_F_TRAIL 9:5
`define UFM_F_MATCH 17:10
// Command register bits.
`define UFM_K_MUTE 0
`define UFM_K_BREAK 1
// Reset values, frame sizes, compare masks and bus answers.
`define UFM_RST_BAUD 16'h0010
`define UFM_W8 4'h8
`define UFM_W9 4'h9
`define UFM_BRK_TX 4'hC
`define UFM_BRK_10 4'hA
`define UFM_BRK_11 4'hB
`define UFM_M4 9'h00F
`define UFM_M6 9'h03F
`define UFM_M7 9'h07F
`define UFM_M8 9'h0FF
`define UFM_OKAY 2'h0
`define UFM_SLVERR 2'h2
`endif

// [ufm_pkg.sv]
// ufm_pkg: state types of the serial extension block.
// Assumes ufm_cfg.svh supplies the addresses, bit positions, reset values and sizes used by the modules.
package ufm_pkg;
  // Transmit sequencer states.
  typedef enum logic [2:0] {UFM_T_IDLE, UFM_T_LEAD, UFM_T_START,
    UFM_T_DATA, UFM_T_STOP, UFM_T_TRAIL} ufm_tx_st_t;
  // Asynchronous receive states.
  typedef enum logic [1:0] {UFM_R_IDLE, UFM_R_START, UFM_R_DATA,
    UFM_R_STOP} ufm_rx_st_t;
  // State of the block in one record; the pin synchroniser keeps its own stages.
  typedef struct packed {
    logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] waddr;
    logic [31:0] wdata, rdata, ctl, cfg;
    logic [3:0] wstrb;
    logic [15:0] baud, tcnt, rcnt, lcnt;
    logic transmit_empty_flag, tx_done, receive_not_empty_flag, idle, framing_fault_flag, overrun_fault_flag, noise_fault_flag, break_seen_flag, mute;
    logic [8:0] tdata, rxbuf, tshift, rshift;
    ufm_tx_st_t tx_st;
    ufm_rx_st_t rx_st;
    logic [3:0] tbit, rbit, idle_cnt, lbits;
    logic [4:0] decnt;
    logic tbrk, brk_req, rnoise, rprev, idle_arm;
    logic o_tx, o_rts, o_de, o_sck, o_irq, o_dtx, o_drx;
  } ufm_state_t;
endpackage : ufm_pkg

// [ufm_sync2.sv]
// ufm_sync2: two-stage synchroniser for asynchronous pin inputs.
// Assumes the inputs idle high and may change at any time.
`timescale 1ns/10ps
module ufm_sync2 #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage; only the second stage reads it.
  logic [W-1:0] meta_reg;

  // Both stages reset to the idle-high line level.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      q <= '1;
    end else if (clk_en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : ufm_sync2

// [ufm_uart_ext.sv]
// ufm_uart_ext: DMA requests, flow control, driver enable, mute wake-up,
// LIN break and synchronous clock around a small serial transceiver.
// Assumes one clock, an AXI4-Lite master and a DMA controller on the
// near side, and a remote serial node on the pins.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "ufm_cfg.svh"
module ufm_uart_ext
  import ufm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_in,
  input wire logic clear_to_send_n,
  output logic tx_out,
  output logic request_to_send_n,
  output logic driver_enable_out,
  output logic sync_clk_pin,
  output logic irq,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  ufm_state_t st, nx;   // Registered state and its next value.
  logic rx_s, cts_s;    // Synchronised pin levels.

  // Frame data bits: LIN forces eight.
  function automatic logic [3:0] frame_bits(input logic [31:0] c);
    return (c[`UFM_C_LIN] || !c[`UFM_C_WL9]) ? `UFM_W8 : `UFM_W9;
  endfunction : frame_bits

  // Wake-up compare of a received frame against the match field.
  function automatic logic match_ok(input logic [8:0] f,
      input logic [3:0] nb, input logic [31:0] c, input logic [7:0] m);
    logic [8:0] mask;
    if (c[`UFM_C_PAR]) begin
      mask = (nb == `UFM_W9) ? `UFM_M8 : `UFM_M6;
    end else if (c[`UFM_C_WAKE_HI]) begin
      mask = `UFM_M8;
    end else begin
      mask = c[`UFM_C_MWID] ? `UFM_M7 : `UFM_M4;
    end
    return ((f ^ {1'b0, m}) & mask) == '0;
  endfunction : match_ok

  // Transmit word with even parity placed in the MSB when enabled.
  function automatic logic [8:0] tx_word(input logic [8:0] d,
      input logic [3:0] nb, input logic par);
    logic [8:0] w;
    w = (nb == `UFM_W9) ? d : {1'b0, d[7:0]};
    if (par && nb == `UFM_W9) begin
      w[8] = ^w[7:0];
    end else if (par) begin
      w[7] = ^w[6:0];
    end
    return w;
  endfunction : tx_word

  // Byte-lane merge of a bus write into a register.
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Pins from the far side are synchronised before any logic.
  ufm_sync2 #(.W(2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d({rx_in, clear_to_send_n}),
    .q({rx_s, cts_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, transmitter, receiver, break, outputs.
  always_comb begin
    logic [3:0] nb;
    logic [31:0] wv, sv;
    logic [8:0] frm;
    logic [15:0] half;
    logic go, tick_t, tick_r, rx_done, fe, ne, keep, sync_m, act;
    nb = frame_bits(st.ctl);
    wv = merge(st.wdata, st.wdata, 4'hF);
    frm = '0;
    half = {1'b0, st.baud[15:1]};
    go = 1'b0;
    rx_done = 1'b0;
    fe = 1'b0;
    ne = 1'b0;
    keep = 1'b1;
    act = 1'b0;
    sync_m = st.ctl[`UFM_C_SCK] && !st.ctl[`UFM_C_LIN];
    tick_t = (st.tcnt == '0);
    tick_r = (st.rcnt == '0);
    sv = '0;
    sv[`UFM_S_TXEMPTY] = st.transmit_empty_flag;
    sv[`UFM_S_TXDONE] = st.tx_done;
    sv[`UFM_S_RXFULL] = st.receive_not_empty_flag;
    sv[`UFM_S_IDLE] = st.idle;
    sv[`UFM_S_FRAME] = st.framing_fault_flag;
    sv[`UFM_S_OVER] = st.overrun_fault_flag;
    sv[`UFM_S_NOISE] = st.noise_fault_flag;
    sv[`UFM_S_BREAK] = st.break_seen_flag;
    sv[`UFM_S_MSTATE] = st.mute;
    nx = st;

    // Address and data are taken in either order; the write acts once
    // both are held, so the response always follows both.
    if (s_axi_awvalid && st.aw_rdy) begin
      nx.aw_rdy = 1'b0;
      nx.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.w_rdy) begin
      nx.w_rdy = 1'b0;
      nx.wdata = s_axi_wdata;
      nx.wstrb = s_axi_wstrb;
    end
    if (!st.aw_rdy && !st.w_rdy && !st.bvalid) begin
      nx.bvalid = 1'b1;
      nx.bresp = `UFM_OKAY;
      wv = merge('0, st.wdata, st.wstrb);
      case (st.waddr)
        `UFM_A_CTRL: begin
          nx.ctl = merge(st.ctl, st.wdata, st.wstrb);
        end
        `UFM_A_CFG: begin
          nx.cfg = merge(st.cfg, st.wdata, st.wstrb);
        end
        `UFM_A_BAUD: begin
          nx.baud = 16'(merge({16'h0000, st.baud}, st.wdata, st.wstrb));
        end
        `UFM_A_STAT: begin
          // Write one to clear; a hardware set below still wins.
          nx.tx_done = st.tx_done && !wv[`UFM_S_TXDONE];
          nx.idle = st.idle && !wv[`UFM_S_IDLE];
          nx.framing_fault_flag = st.framing_fault_flag && !wv[`UFM_S_FRAME];
          nx.overrun_fault_flag = st.overrun_fault_flag && !wv[`UFM_S_OVER];
          nx.noise_fault_flag = st.noise_fault_flag && !wv[`UFM_S_NOISE];
          nx.break_seen_flag = st.break_seen_flag && !wv[`UFM_S_BREAK];
        end
        `UFM_A_TXD: begin
          nx.tdata = wv[8:0];
          nx.transmit_empty_flag = 1'b0;
          nx.tx_done = 1'b0;
        end
        `UFM_A_RXD: begin
          nx.bresp = `UFM_OKAY;
        end
        `UFM_A_CMD: begin
          if (wv[`UFM_K_MUTE] && st.ctl[`UFM_C_MUTE]) begin
            nx.mute = 1'b1;
          end
          if (wv[`UFM_K_BREAK]) begin
            nx.brk_req = 1'b1;
          end
        end
        default: begin
          nx.bresp = `UFM_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
      nx.aw_rdy = 1'b1;
      nx.w_rdy = 1'b1;
    end

    // Reads answer in the cycle after the address is taken.
    if (s_axi_arvalid && st.ar_rdy) begin
      nx.ar_rdy = 1'b0;
      nx.rvalid = 1'b1;
      nx.rresp = `UFM_OKAY;
      case (s_axi_araddr)
        `UFM_A_CTRL: nx.rdata = st.ctl;
        `UFM_A_CFG: nx.rdata = st.cfg;
        `UFM_A_BAUD: nx.rdata = {16'h0000, st.baud};
        `UFM_A_STAT: nx.rdata = sv;
        `UFM_A_TXD: nx.rdata = {23'h000000, st.tdata};
        `UFM_A_RXD: begin
          nx.rdata = {23'h000000, st.rxbuf};
          nx.receive_not_empty_flag = 1'b0;
        end
        `UFM_A_CMD: nx.rdata = '0;
        default: begin
          nx.rdata = '0;
          nx.rresp = `UFM_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
      nx.ar_rdy = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Transmitter. Bit timing counts down from the divisor.
    if (st.tx_st != UFM_T_IDLE) begin
      nx.tcnt = tick_t ? st.baud - 16'h0001 : st.tcnt - 16'h0001;
    end
    case (st.tx_st)
      UFM_T_IDLE: begin
        if (st.ctl[`UFM_C_UNIT] && st.ctl[`UFM_C_TXON]) begin
          if (st.brk_req) begin
            // Break: thirteen zero bits, then one stop bit.
            go = 1'b1;
            nx.brk_req = 1'b0;
            nx.tbrk = 1'b1;
            nx.tshift = '0;
            // The start bit is the first of the thirteen zeros.
            nx.tbit = `UFM_BRK_TX - 4'h1;
          end else if (!st.transmit_empty_flag && (!st.ctl[`UFM_C_CLFL] || !cts_s)) begin
            go = 1'b1;
            nx.tbrk = 1'b0;
            nx.tshift = tx_word(st.tdata, nb, st.ctl[`UFM_C_PAR]);
            nx.tbit = nb - 4'h1;
            nx.transmit_empty_flag = 1'b1;
          end
        end
        if (go) begin
          nx.tcnt = st.baud - 16'h0001;
          nx.decnt = st.cfg[`UFM_F_LEAD];
          nx.tx_st = (st.ctl[`UFM_C_XCVR] && st.cfg[`UFM_F_LEAD] != '0)
              ? UFM_T_LEAD : UFM_T_START;
        end
      end
      UFM_T_LEAD: begin
        if (tick_t && st.decnt <= 5'h01) begin
          nx.tx_st = UFM_T_START;
        end else if (tick_t) begin
          nx.decnt = st.decnt - 5'h01;
        end
      end
      UFM_T_START: begin
        if (tick_t) begin
          nx.tx_st = UFM_T_DATA;
        end
      end
      UFM_T_DATA: begin
        // The sync receiver samples once, at the capture instant.
        if (sync_m && st.tcnt == half) begin
          nx.rshift = {rx_s, st.rshift[8:1]};
        end
        if (tick_t) begin
          nx.tshift = {1'b0, st.tshift[8:1]};
          nx.tbit = st.tbit - 4'h1;
          if (st.tbit == '0) begin
            nx.tx_st = UFM_T_STOP;
          end
        end
      end
      UFM_T_STOP: begin
        // A frame is always finished; the clear input only gates the
        // next start back in the idle state.
        if (tick_t) begin
          nx.tx_st = UFM_T_IDLE;
          if (st.ctl[`UFM_C_XCVR] && st.cfg[`UFM_F_TRAIL] != '0) begin
            nx.tx_st = UFM_T_TRAIL;
            nx.decnt = st.cfg[`UFM_F_TRAIL];
          end
          if (nx.transmit_empty_flag) begin
            nx.tx_done = 1'b1;
          end
          if (sync_m && st.ctl[`UFM_C_RXON] && !st.tbrk) begin
            rx_done = 1'b1;
            frm = st.rshift >> (4'h9 - nb);
          end
        end
      end
      UFM_T_TRAIL: begin
        if (tick_t && st.decnt <= 5'h01) begin
          nx.tx_st = UFM_T_IDLE;
        end else if (tick_t) begin
          nx.decnt = st.decnt - 5'h01;
        end
      end
      default: nx.tx_st = UFM_T_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////
    // Asynchronous receiver: one mid-bit sample; noise is flagged when
    // the line changed in the cycle before that sample.
    nx.rprev = rx_s;
    nx.rcnt = tick_r ? st.baud - 16'h0001 : st.rcnt - 16'h0001;
    if (sync_m || !st.ctl[`UFM_C_RXON] || !st.ctl[`UFM_C_UNIT]) begin
      nx.rx_st = UFM_R_IDLE;
    end else begin
      case (st.rx_st)
        UFM_R_IDLE: begin
          if (!rx_s) begin
            // A line still low after a break waits for a rise first,
            // so one break gives one frame and no phantom overrun.
            if (st.rprev) begin
              nx.rx_st = UFM_R_START;
              nx.rcnt = half;
            end
            nx.idle_cnt = '0;
          end else if (tick_r && st.idle_cnt == nb + 4'h1) begin
            nx.idle_cnt = '0;
            nx.idle_arm = 1'b0;
            if (st.idle_arm && st.mute && st.ctl[`UFM_C_MUTE]
                && st.ctl[`UFM_C_WAKE_HI:`UFM_C_WAKE] == 2'h0) begin
              nx.mute = 1'b0;
            end else if (st.idle_arm && !st.mute) begin
              nx.idle = 1'b1;
            end
          end else if (tick_r) begin
            nx.idle_cnt = st.idle_cnt + 4'h1;
          end
        end
        UFM_R_START: begin
          if (tick_r) begin
            nx.rx_st = rx_s ? UFM_R_IDLE : UFM_R_DATA;
            nx.rnoise = (rx_s != st.rprev);
            nx.rbit = nb - 4'h1;
          end
        end
        UFM_R_DATA: begin
          if (tick_r) begin
            nx.rshift = {rx_s, st.rshift[8:1]};
            nx.rnoise = st.rnoise || (rx_s != st.rprev);
            nx.rbit = st.rbit - 4'h1;
            if (st.rbit == '0) begin
              nx.rx_st = UFM_R_STOP;
            end
          end
        end
        UFM_R_STOP: begin
          if (tick_r) begin
            rx_done = 1'b1;
            fe = !rx_s;
            ne = st.rnoise || (rx_s != st.rprev);
            frm = st.rshift >> (4'h9 - nb);
            nx.rx_st = UFM_R_IDLE;
            nx.idle_arm = 1'b1;
            nx.idle_cnt = '0;
          end
        end
        default: nx.rx_st = UFM_R_IDLE;
      endcase
    end

    // Wake-up methods decide whether a finished frame is kept.
    if (rx_done && st.ctl[`UFM_C_MUTE]) begin
      if (st.ctl[`UFM_C_WAKE_HI]) begin
        nx.mute = !match_ok(frm, nb, st.ctl, st.cfg[`UFM_F_MATCH]);
        keep = !nx.mute;
      end else if (st.ctl[`UFM_C_WAKE]) begin
        if (st.ctl[`UFM_C_PAR] ? frm[nb - 4'h2] : frm[nb - 4'h1]) begin
          nx.mute = !match_ok(frm, nb, st.ctl, st.cfg[`UFM_F_MATCH]);
        end
        keep = !nx.mute;
      end else begin
        keep = !st.mute;
      end
    end
    if (rx_done && keep) begin
      if (nx.receive_not_empty_flag) begin
        nx.overrun_fault_flag = 1'b1;
      end else begin
        nx.rxbuf = frm;
        nx.receive_not_empty_flag = 1'b1;
      end
      // Built on the next value, so a clear in this cycle is not lost.
      nx.framing_fault_flag = nx.framing_fault_flag || fe;
      nx.noise_fault_flag = nx.noise_fault_flag || ne;
    end

    // Break detector runs beside the receiver in bit periods of low.
    if (rx_s) begin
      nx.lcnt = st.baud - 16'h0001;
      nx.lbits = '0;
    end else if (st.lcnt != '0) begin
      nx.lcnt = st.lcnt - 16'h0001;
    end else begin
      nx.lcnt = st.baud - 16'h0001;
      if (st.lbits != 4'hF) begin
        nx.lbits = st.lbits + 4'h1;
      end
      if (st.lbits + 4'h1 == (st.ctl[`UFM_C_BLEN] ? `UFM_BRK_11
          : `UFM_BRK_10) && st.ctl[`UFM_C_LIN] && !st.mute) begin
        nx.break_seen_flag = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////
    // Output pins and requests, registered from the next state.
    nx.o_tx = !(nx.tx_st == UFM_T_START
        || (nx.tx_st == UFM_T_DATA && !nx.tshift[0]));
    act = sync_m && st.ctl[`UFM_C_TXON] && nx.tx_st == UFM_T_DATA
        && !nx.tbrk && (nx.tbit != '0 || st.ctl[`UFM_C_LAST]);
    nx.o_sck = st.ctl[`UFM_C_IDLV] ^ (act && (st.ctl[`UFM_C_PHASE]
        ? nx.tcnt > half : nx.tcnt <= half));
    nx.o_de = st.ctl[`UFM_C_DPOL] ^ (st.ctl[`UFM_C_XCVR]
        && nx.tx_st != UFM_T_IDLE);
    nx.o_rts = st.ctl[`UFM_C_RQFL] && nx.receive_not_empty_flag;
    nx.o_irq = (st.ctl[`UFM_C_TCIRQ] && nx.tx_done)
        || (st.ctl[`UFM_C_ERIRQ] && (nx.framing_fault_flag || nx.overrun_fault_flag || nx.noise_fault_flag))
        || (st.ctl[`UFM_C_BKIRQ] && nx.break_seen_flag);
    nx.o_dtx = nx.ctl[`UFM_C_DMATX] && nx.transmit_empty_flag;
    nx.o_drx = nx.ctl[`UFM_C_DMARX] && nx.receive_not_empty_flag;
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, transmit_empty_flag: 1'b1,
        baud: `UFM_RST_BAUD, o_tx: 1'b1, tx_st: UFM_T_IDLE,
        rx_st: UFM_R_IDLE, rprev: 1'b1, default: '0};
    end else if (clk_en) begin
      st <= nx;
    end
  end

  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready = st.w_rdy;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign tx_out = st.o_tx;
  assign request_to_send_n = st.o_rts;
  assign driver_enable_out = st.o_de;
  assign sync_clk_pin = st.o_sck;
  assign irq = st.o_irq;
  assign dma_tx_req = st.o_dtx;
  assign dma_rx_req = st.o_drx;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  dma_tx_gate_a: assert property (dma_tx_req |-> st.ctl[`UFM_C_DMATX]
      && st.transmit_empty_flag) else $error("transmit request without cause");
  dma_rx_gate_a: assert property (dma_rx_req == (st.ctl[`UFM_C_DMARX]
      && st.receive_not_empty_flag)) else $error("receive request mismatch");
  rts_full_a: assert property ($rose(st.receive_not_empty_flag) && st.ctl[`UFM_C_RQFL]
      |-> request_to_send_n) else $error("request not raised");
  cts_start_a: assert property ($past(st.tx_st) == UFM_T_IDLE
      && st.tx_st != UFM_T_IDLE && !st.tbrk && $past(st.ctl[`UFM_C_CLFL])
      |-> !$past(cts_s)) else $error("frame started while paused");
  de_lead_a: assert property (st.tx_st == UFM_T_LEAD
      |-> driver_enable_out != st.ctl[`UFM_C_DPOL])
      else $error("driver not active in lead");
  de_off_a: assert property (!st.ctl[`UFM_C_XCVR]
      && $past(!st.ctl[`UFM_C_XCVR]) |-> driver_enable_out
      == st.ctl[`UFM_C_DPOL]) else $error("driver active outside mode");
  mute_quiet_a: assert property ($past(st.mute) && st.mute
      |-> !$rose(st.receive_not_empty_flag)) else $error("flag set while muted");
  break_flag_a: assert property ($rose(st.break_seen_flag) |-> !$past(rx_s)
      && $past(st.ctl[`UFM_C_LIN])) else $error("break flag without low");
  sck_idle_a: assert property (st.tx_st != UFM_T_DATA
      && $past(st.tx_st) != UFM_T_DATA |-> sync_clk_pin
      == $past(st.ctl[`UFM_C_IDLV])) else $error("clock outside data");
  tx_done_a: assert property ($rose(st.tx_done) |->
      $past(st.tx_st) == UFM_T_STOP && st.transmit_empty_flag)
      else $error("done flag without frame end");

  dma_tx_c: cover property (dma_tx_req ##1 !st.transmit_empty_flag);
  break_c: cover property ($rose(st.break_seen_flag));
  wake_c: cover property ($fell(st.mute) && st.receive_not_empty_flag);
  sync_c: cover property ($rose(sync_clk_pin ^ st.ctl[`UFM_C_IDLV]));
endmodule : ufm_uart_ext

// [ufm_remote.sv]
// ufm_remote: remote serial node on the receive and flow pins.
// Assumes the block's bit period is given in clocks by the caller.
`timescale 1ns/10ps
module ufm_remote (
  input wire logic clock,
  output logic rx_in,
  output logic clear_to_send_n
);
  // Line idles high; the sender starts paused.
  initial begin
    rx_in = 1'b1;
    clear_to_send_n = 1'b1;
  end
  // Pause or release the block's sender between frames.
  task automatic cts(input logic v);
    clear_to_send_n <= v;
  endtask : cts
  // One frame: start, eight bits LSB first, one stop.
  task automatic send(input logic [7:0] d, input int bp);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_in <= f[i];
      repeat (bp) @(posedge clock);
    end
  endtask : send
  // Hold the line low for n clocks, then release it high.
  task automatic brk(input int n);
    rx_in <= 1'b0;
    repeat (n) @(posedge clock);
    rx_in <= 1'b1;
  endtask : brk
endmodule : ufm_remote

// [tb_uart_flow_mute_lin_sync.sv]
// tb_uart_flow_mute_lin_sync: register rows, then transmit, receive,
// mute and break cases against the remote node model.
// Assumes ufm_cfg.svh and ufm_pkg are compiled first.
`timescale 1ns/10ps
`include "ufm_cfg.svh"
module tb_uart_flow_mute_lin_sync
  import ufm_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [31:0] d, e;
    logic [1:0] r;
  } ufm_row_t;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Ready lines stay high; AXI allows a master to wait ready.
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  logic pv = 1'b0;
  logic rx_in, clear_to_send_n, tx_out, request_to_send_n;
  logic driver_enable_out, sync_clk_pin, irq, dma_tx_req, dma_rx_req;
  logic [8:0] b;
  int err_total = 0, compares = 0, nl = 0, nr = 0;
  // Register rows: optional write, then a read with expected answer.
  ufm_row_t rows [5] = '{
    '{`UFM_A_BAUD, 1'b0, 32'h0, 32'h10, `UFM_OKAY},
    '{`UFM_A_CFG, 1'b1, 32'h15462, 32'h15462, `UFM_OKAY},
    '{`UFM_A_BAUD, 1'b1, 32'h8, 32'h8, `UFM_OKAY},
    '{`UFM_A_STAT, 1'b0, 32'h0, 32'h1, `UFM_OKAY},
    '{8'h1C, 1'b1, 32'h0, 32'h0, `UFM_SLVERR}};
  ufm_uart_ext dut (.clock, .rst_n, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in,
    .clear_to_send_n, .tx_out, .request_to_send_n, .driver_enable_out,
    .sync_clk_pin, .irq, .dma_tx_req, .dma_rx_req);
  ufm_remote rm (.clock, .rx_in, .clear_to_send_n);
  ////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock.
  always #5 clock = ~clock;
  // Compare one value and count it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // One AXI write; each channel drops when its ready is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    brsp = s_axi_bresp;
  endtask : wr
  // One AXI read; data and response taken at the rvalid edge.
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask : rd
  // Count low line cycles and rising clock-pin edges over c cycles.
  task automatic watch(input int c);
    nl = 0;
    nr = 0;
    for (int i = 0; i < c; i++) begin
      @(posedge clock);
      nl += !tx_out;
      nr += sync_clk_pin && !pv;
      pv = sync_clk_pin;
    end
  endtask : watch
  // Print the counts and the verdict, then stop.
  task automatic conclude;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  // Main sequence; the bit period is 8 clocks, lead 2 and trail 3 bits.
  initial begin
    repeat (4) @(posedge clock);
    chk(tx_out, 1);
    chk(dma_tx_req, 0);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        chk(brsp, rows[i].r);
      end
      rd(rows[i].a);
      chk(rdat, rows[i].e);
      chk(rrsp, rows[i].r);
    end
    // Unit, both directions, both DMA, both flow controls, driver on.
    wr(`UFM_A_CTRL, 32'h3E7);
    repeat (3) @(posedge clock);
    chk(dma_tx_req, 1);
    wr(`UFM_A_TXD, 32'h5A);
    repeat (20) @(posedge clock);
    chk(tx_out, 1);
    chk(dma_tx_req, 0);
    rm.cts(1'b0);
    while (tx_out !== 1'b0) @(posedge clock);
    chk(driver_enable_out, 1);
    repeat (4) @(posedge clock);
    rm.cts(1'b1);
    for (int i = 0; i < 9; i++) begin
      repeat (8) @(posedge clock);
      b[i] = tx_out;
    end
    chk(b, 9'h15A);
    repeat (8) @(posedge clock);
    chk(driver_enable_out, 1);
    repeat (28) @(posedge clock);
    chk(driver_enable_out, 0);
    rd(`UFM_A_STAT);
    chk(rdat & 32'h3, 32'h3);
    rm.send(8'hA5, 8);
    repeat (4) @(posedge clock);
    chk(request_to_send_n, 1);
    chk(dma_rx_req, 1);
    rd(`UFM_A_RXD);
    chk(rdat, 32'hA5);
    repeat (2) @(posedge clock);
    chk(dma_rx_req, 0);
    // Let the idle frame pass before muting, so it cannot wake us.
    repeat (120) @(posedge clock);
    wr(`UFM_A_CTRL, 32'hBE7);
    wr(`UFM_A_STAT, 32'hF8);
    wr(`UFM_A_CMD, 32'h1);
    rm.send(8'h3C, 8);
    rd(`UFM_A_STAT);
    chk(rdat & 32'h104, 32'h100);
    repeat (100) @(posedge clock);
    rd(`UFM_A_STAT);
    chk(rdat & 32'h10C, 32'h0);
    // LIN with break interrupt; line held low for twelve bits.
    wr(`UFM_A_CTRL, 32'h8083E7);
    wr(`UFM_A_STAT, 32'hF8);
    rm.brk(96);
    repeat (8) @(posedge clock);
    rd(`UFM_A_STAT);
    chk(rdat & 32'h90, 32'h90);
    chk(irq, 1);
    // Sync master: clock settings change only with the unit off.
    wr(`UFM_A_CTRL, 32'h0);
    wr(`UFM_A_CTRL, 32'h60002);
    wr(`UFM_A_CTRL, 32'h60003);
    wr(`UFM_A_TXD, 32'hA5);
    watch(120);
    chk(nl, 40);
    chk(nr, 8);
    // Break: thirteen zero bits with the clock pin left idle.
    wr(`UFM_A_CMD, 32'h2);
    watch(160);
    chk(nl, 104);
    chk(nr, 0);
    conclude;
  end
  // Watchdog well beyond the roughly one thousand cycles the run needs.
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule : tb_uart_flow_mute_lin_sync
